// ==== pkg/sbm_consts.svh ====
// Offsets, field positions, reset values and timing figures of the measurement sequencer.
// Assumes inclusion by bare name; it holds definitions only.
`ifndef SBM_CONSTS_SVH
`define SBM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SBM_OFS_CFG 8'h00
`define SBM_OFS_SHUNT 8'h04
`define SBM_OFS_BUS 8'h08
`define SBM_OFS_PWR 8'h0c
`define SBM_OFS_CUR 8'h10
`define SBM_OFS_CAL 8'h14
`define SBM_OFS_STATUS 8'h18
`define SBM_OFS_IRQ_STAT 8'h1c
`define SBM_OFS_IRQ_MASK 8'h20

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SBM_CFG_W 12
`define SBM_CFG_RST 12'h127
`define SBM_IRQ_W 2
`define SBM_IRQ_DONE 0
`define SBM_IRQ_WAKE 1

// ----------------------------------------
// Timing: clock rate, conversion and recovery times; current and power shifts
// ----------------------------------------
`define SBM_CLK_MHZ 25
`define SBM_CT_US_LIST 140, 204, 332, 588, 1100, 2116, 4156, 8244
`define SBM_RECOVERY_US 40000
`define SBM_CUR_SHIFT 11
`define SBM_PWR_SHIFT 13

`endif

// ==== pkg/sbm_pkg.sv ====
// Types shared by the measurement sequencer and its bench.
// Assumes the constants header is on the include path.
package sbm_pkg;

  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] avg;       // Log2 of the averaging count
    logic [2:0] bus_ct;    // Bus conversion_time_code
    logic [2:0] shunt_ct;  // Shunt conversion_time_code
    logic [2:0] mode;      // Operating mode
  } sbm_cfg_t;

  // ----------------------------------------
  // One averaged result set
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] cur;
    logic [15:0] pwr;
  } sbm_res_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SBM_OFF,
    SBM_WAKE,
    SBM_IDLE,
    SBM_SHUNT,
    SBM_BUS
  } sbm_state_t;

endpackage

// ==== design/sbm_sequencer.sv ====
// Shunt and bus measurement sequencer with APB register file and interrupt.
// Assumes an outside converter front end that presents shunt_code and bus_code
// as steady values, sampled at the end of each conversion window.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "sbm_consts.svh"

module sbm_sequencer
  import sbm_pkg::*;
#(
  parameter int unsigned CLK_MHZ = `SBM_CLK_MHZ,
  parameter int unsigned CT_US [8] = '{`SBM_CT_US_LIST},
  parameter int unsigned RECOVERY_US = `SBM_RECOVERY_US,
  parameter int unsigned CUR_SHIFT = `SBM_CUR_SHIFT,
  parameter int unsigned PWR_SHIFT = `SBM_PWR_SHIFT
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] shunt_code,
  input wire logic [15:0] bus_code,
  output logic front_end_on,
  output logic conv_shunt,
  output logic conv_bus,
  output logic irq
);

  // ----------------------------------------
  // Derived cycle counts
  // ----------------------------------------
  // Recovery count, far above 4096 cycles, so a bench shortens RECOVERY_US
  localparam int unsigned WAKE_CYC = RECOVERY_US * CLK_MHZ;

  // Conversion window length for one conversion_time_code
  function automatic logic [31:0] conv_cyc(input logic [2:0] code);
    int unsigned n;
    n = CT_US[code] * CLK_MHZ;
    conv_cyc = (n == 0) ? 32'h1 : 32'(n);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  sbm_state_t state, next_state;               // Sequencer state
  logic [31:0] cnt, next_cnt;                  // Window counter
  logic [7:0] nsamp, next_nsamp;               // Samples taken in this run
  logic signed [31:0] acc_s, next_acc_s;       // Shunt accumulator
  logic signed [31:0] acc_b, next_acc_b;       // Bus accumulator
  logic signed [31:0] acc_c, next_acc_c;       // Current accumulator
  logic signed [31:0] acc_p, next_acc_p;       // Power accumulator
  logic signed [15:0] last_cur, next_last_cur; // Current used by the power step
  sbm_res_t res, next_res;                     // Output result registers
  sbm_cfg_t cfg, next_cfg;                     // Configuration register
  logic [15:0] cal, next_cal;                  // Calibration register
  logic rdy, next_rdy;                         // conversion_ready_flag
  logic [`SBM_IRQ_W-1:0] irq_stat, next_irq_stat; // Sticky events
  logic [`SBM_IRQ_W-1:0] irq_mask, next_irq_mask; // Interrupt enables

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc_wr;          // Write access phase
  logic acc_rd;          // Read access phase
  logic mapped;          // Address hits a register
  logic cfg_wr;          // Configuration write this cycle
  logic stat_rd;         // Status read this cycle
  sbm_cfg_t wr_cfg;      // Configuration being written

  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign wr_cfg = sbm_cfg_t'(pwdata[`SBM_CFG_W-1:0]);
  assign cfg_wr = acc_wr && (paddr == `SBM_OFS_CFG);
  assign stat_rd = acc_rd && (paddr == `SBM_OFS_STATUS);
  // Zero wait states: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read mux; reads have no side effect on the sequence, only on the flag
  always_comb
  begin
    mapped = 1'b1;
    prdata = 32'h0;
    if (paddr == `SBM_OFS_CFG)
      prdata = {20'h0, cfg};
    else if (paddr == `SBM_OFS_SHUNT)
      prdata = {16'h0, res.shunt};
    else if (paddr == `SBM_OFS_BUS)
      prdata = {16'h0, res.bus};
    else if (paddr == `SBM_OFS_PWR)
      prdata = {16'h0, res.pwr};
    else if (paddr == `SBM_OFS_CUR)
      prdata = {16'h0, res.cur};
    else if (paddr == `SBM_OFS_CAL)
      prdata = {16'h0, cal};
    else if (paddr == `SBM_OFS_STATUS)
      prdata = {30'h0, front_end_on, rdy};
    else if (paddr == `SBM_OFS_IRQ_STAT)
      prdata = {30'h0, irq_stat};
    else if (paddr == `SBM_OFS_IRQ_MASK)
      prdata = {30'h0, irq_mask};
    else
    begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------
  // Background arithmetic
  // ----------------------------------------
  logic signed [32:0] cur_prod; // Shunt times calibration
  logic signed [15:0] cur_calc; // Current from this shunt sample
  logic [16:0] cur_mag;         // Magnitude of the current
  logic [32:0] pwr_prod;        // Magnitude times bus code
  logic [15:0] pwr_calc;        // Power from this bus sample

  // Combinational so a sample and its derived values land on the same edge
  always_comb
  begin
    cur_prod = 33'(shunt_code) * $signed({17'h0, cal});
    cur_calc = (cal == 16'h0) ? 16'sh0 : 16'(cur_prod >>> CUR_SHIFT);
    cur_mag = last_cur[15] ? 17'(-32'(last_cur)) : 17'(32'(last_cur));
    pwr_prod = 33'(cur_mag) * 33'(bus_code);
    pwr_calc = (cal == 16'h0) ? 16'h0 : 16'(pwr_prod >> PWR_SHIFT);
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic pd_now;          // Current mode is power-down
  logic pd_new;          // Written mode is power-down
  logic last_sample;     // This sample completes the averaging run
  sbm_state_t first_st;  // First conversion of a sample, current cfg
  sbm_state_t first_new; // First conversion of a sample, written cfg

  assign pd_now = (cfg.mode[1:0] == 2'b00);
  assign pd_new = (wr_cfg.mode[1:0] == 2'b00);
  // Mode bit 0 enables shunt, bit 1 enables bus
  assign first_st = cfg.mode[0] ? SBM_SHUNT : SBM_BUS;
  assign first_new = wr_cfg.mode[0] ? SBM_SHUNT : SBM_BUS;
  assign last_sample = (nsamp == 8'((9'h1 << cfg.avg) - 9'h1));

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + 32'h1;
    next_nsamp = nsamp;
    next_acc_s = acc_s;
    next_acc_b = acc_b;
    next_acc_c = acc_c;
    next_acc_p = acc_p;
    next_last_cur = last_cur;
    next_res = res;
    next_cfg = cfg;
    next_cal = cal;
    next_rdy = rdy;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    // Register writes, accepted in every state
    if (acc_wr && paddr == `SBM_OFS_CAL)
    begin
      next_cal = pwdata[15:0];
    end
    if (acc_wr && paddr == `SBM_OFS_IRQ_MASK)
    begin
      next_irq_mask = pwdata[`SBM_IRQ_W-1:0];
    end
    if (acc_wr && paddr == `SBM_OFS_IRQ_STAT)
    begin
      next_irq_stat = irq_stat & ~pwdata[`SBM_IRQ_W-1:0];
    end
    // Flag clears first, so a completion in the same cycle wins below
    if ((cfg_wr && !pd_new) || stat_rd)
    begin
      next_rdy = 1'b0;
    end
    case (state)
      SBM_OFF:
      begin
        next_cnt = 32'h0;
      end
      SBM_WAKE:
      begin
        // Front end is settling; no sample is taken before recovery ends
        if (cnt == 32'(WAKE_CYC) - 32'h1 || WAKE_CYC == 0)
        begin
          next_state = first_st;
          next_cnt = 32'h0;
          next_irq_stat[`SBM_IRQ_WAKE] = 1'b1;
        end
      end
      SBM_IDLE:
      begin
        next_cnt = 32'h0;
      end
      SBM_SHUNT:
      begin
        if (cnt == conv_cyc(cfg.shunt_ct) - 32'h1)
        begin
          next_acc_s = acc_s + 32'(shunt_code);
          next_acc_c = acc_c + 32'(cur_calc);
          next_last_cur = cur_calc;
          next_cnt = 32'h0;
          if (cfg.mode[1])
          begin
            next_state = SBM_BUS;
          end
        end
      end
      SBM_BUS:
      begin
        if (cnt == conv_cyc(cfg.bus_ct) - 32'h1)
        begin
          next_acc_b = acc_b + $signed({16'h0, bus_code});
          next_acc_p = acc_p + $signed({16'h0, pwr_calc});
          next_cnt = 32'h0;
        end
      end
      default:
      begin
        next_state = SBM_OFF;
      end
    endcase
    // End of one sample: either its last conversion just finished
    if ((state == SBM_BUS && cnt == conv_cyc(cfg.bus_ct) - 32'h1) ||
        (state == SBM_SHUNT && !cfg.mode[1] && cnt == conv_cyc(cfg.shunt_ct) - 32'h1))
    begin
      if (last_sample)
      begin
        // Only converted channels are loaded; the others keep old values
        if (cfg.mode[0])
        begin
          next_res.shunt = 16'(next_acc_s >>> cfg.avg);
          next_res.cur = 16'(next_acc_c >>> cfg.avg);
        end
        if (cfg.mode[1])
        begin
          next_res.bus = 16'(next_acc_b >>> cfg.avg);
          next_res.pwr = 16'(next_acc_p >>> cfg.avg);
        end
        next_acc_s = 32'sh0;
        next_acc_b = 32'sh0;
        next_acc_c = 32'sh0;
        next_acc_p = 32'sh0;
        next_nsamp = 8'h0;
        next_rdy = 1'b1;
        next_irq_stat[`SBM_IRQ_DONE] = 1'b1;
        next_state = cfg.mode[2] ? first_st : SBM_IDLE;
      end
      else
      begin
        next_nsamp = nsamp + 8'h1;
        next_state = first_st;
      end
    end
    // Configuration write overrides the sequence and restarts it, or stops it when the new mode is power-down
    if (cfg_wr)
    begin
      next_cfg = wr_cfg;
      next_cnt = 32'h0;
      next_nsamp = 8'h0;
      next_acc_s = 32'sh0;
      next_acc_b = 32'sh0;
      next_acc_c = 32'sh0;
      next_acc_p = 32'sh0;
      if (pd_new)
      begin
        next_state = SBM_OFF;
      end
      else if (state == SBM_OFF || state == SBM_WAKE)
      begin
        next_state = SBM_WAKE;
      end
      else
      begin
        next_state = first_new;
      end
    end
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  // Reset starts a continuous run with a powered front end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= SBM_SHUNT;
      cnt <= 32'h0;
      nsamp <= 8'h0;
      acc_s <= 32'sh0;
      acc_b <= 32'sh0;
      acc_c <= 32'sh0;
      acc_p <= 32'sh0;
      last_cur <= 16'sh0;
      res <= '0;
      cfg <= sbm_cfg_t'(`SBM_CFG_RST);
      cal <= 16'h0;
      rdy <= 1'b0;
      irq_stat <= '0;
      irq_mask <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      nsamp <= next_nsamp;
      acc_s <= next_acc_s;
      acc_b <= next_acc_b;
      acc_c <= next_acc_c;
      acc_p <= next_acc_p;
      last_cur <= next_last_cur;
      res <= next_res;
      cfg <= next_cfg;
      cal <= next_cal;
      rdy <= next_rdy;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Front end is powered except in power-down
  assign front_end_on = (state != SBM_OFF);
  assign conv_shunt = (state == SBM_SHUNT);
  assign conv_bus = (state == SBM_BUS);
  assign irq = |(irq_stat & irq_mask);

endmodule

// ==== dv/sbm_fe_model.sv ====
// Converter front end model facing the sequencer.
// Assumes windows are flagged by conv_shunt and conv_bus.
`timescale 1ns/100ps
module sbm_fe_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conv_shunt,
  input wire logic conv_bus,
  output logic signed [15:0] shunt_code,
  output logic [15:0] bus_code
);
  logic flip; // Shunt level toggles each time conv_shunt falls
  logic shunt_q; // Window flag one cycle late, to see its falling edge
  logic [15:0] junk; // Outside a window the code is not held
  // Pattern steps each cycle so a late sample never matches
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      flip <= 1'b0;
      shunt_q <= 1'b0;
      junk <= 16'h5a5a;
    end
    else
    begin
      junk <= ~junk + 16'h0001;
      shunt_q <= conv_shunt;
      if (shunt_q && !conv_shunt)
        flip <= ~flip;
    end
  end
  assign shunt_code = conv_shunt ? (flip ? 16'sh0258 : 16'sh0190) : junk;
  assign bus_code = conv_bus ? 16'h1f40 : ~junk;
endmodule

// ==== dv/sbm_sequencer_asserts.sv ====
// Port checker of the measurement sequencer.
// Assumes it is bound to every sequencer instance.
`timescale 1ns/100ps
module sbm_sequencer_asserts
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic front_end_on,
  input wire logic conv_shunt,
  input wire logic conv_bus
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic acc; // Access phase
  logic cfg_wr; // Configuration write commit
  assign acc = psel && penable;
  assign cfg_wr = acc && pwrite && paddr == 8'h00;
  sequence s_wake_req;
    cfg_wr && pwdata[1:0] != 2'b00 && !front_end_on;
  endsequence
  sequence s_quiet2;
    (!conv_shunt && !conv_bus)[*2];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_access_ready: assert property (acc |-> pready) else $error("no ready");
  a_unmapped_err: assert property (acc && paddr > 8'h20 |-> pslverr && prdata == 32'h0) else $error("bad err");
  a_mapped_ok: assert property (acc && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr) else $error("err");
  a_one_window: assert property (!(conv_shunt && conv_bus)) else $error("two windows");
  a_off_quiet: assert property (!front_end_on |-> !conv_shunt && !conv_bus) else $error("conv off");
  a_off_holds: assert property (!front_end_on && !cfg_wr |=> !front_end_on) else $error("woke");
  a_pd_write: assert property (cfg_wr && pwdata[1:0] == 2'b00 |=> !front_end_on) else $error("no off");
  a_wake_wait: assert property (s_wake_req |=> front_end_on ##0 s_quiet2) else $error("no wait");
  a_read_calm: assert property (acc && !pwrite |=> $stable(front_end_on)) else $error("read effect");
  a_cfg_restart: assert property (cfg_wr && pwdata[1:0] != 2'b00 && (conv_shunt || conv_bus)
    |=> conv_shunt == $past(pwdata[0]) && conv_bus != $past(pwdata[0])) else $error("no restart");
endmodule
bind sbm_sequencer sbm_sequencer_asserts sbm_sequencer_asserts_i (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .front_end_on(front_end_on), .conv_shunt(conv_shunt), .conv_bus(conv_bus));

// ==== dv/tb_shunt_bus_measurement_sequencer.sv ====
// Self-checking bench of the measurement sequencer.
// Assumes short windows: CLK_MHZ 1, so a code's time is its cycle count.
`timescale 1ns/100ps
module tb_shunt_bus_measurement_sequencer;
  import sbm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, front_end_on, conv_shunt, conv_bus, irq;
  logic signed [15:0] shunt_code;
  logic [15:0] bus_code;
  int n_fail = 0;
  int n_tests = 0;
  int c;
  always #20 clk_sys = ~clk_sys;
  sbm_sequencer #(.CLK_MHZ(1), .CT_US('{3, 4, 5, 6, 7, 8, 9, 10}), .RECOVERY_US(2)) sbm_sequencer_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .shunt_code(shunt_code),
    .bus_code(bus_code), .front_end_on(front_end_on), .conv_shunt(conv_shunt), .conv_bus(conv_bus), .irq(irq));
  sbm_fe_model sbm_fe_model_i (.clk_sys(clk_sys), .rst(rst), .conv_shunt(conv_shunt),
    .conv_bus(conv_bus), .shunt_code(shunt_code), .bus_code(bus_code));
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, s, x);
    end
  endtask
  // Setup, access held until ready is seen at an edge, data taken there, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Counts edges until irq is seen, looked at once settled
  task automatic wait_irq(input int lim, output int k);
    for (k = 0; k < lim; k++)
    begin
      #1;
      if (irq === 1'b1)
        break;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdr(8'h00);
    check(rd, 32'h127);
    rdr(8'h14);
    check(rd, 32'h0);
    rdr(8'h20);
    check(rd, 32'h0);
    rdr(8'h24);
    check({31'h0, er}, 32'h1);
  endtask
  // Continuous runs with no calibration keep landing
  task automatic t_zero_cal();
    wr(8'h20, 32'h1);
    repeat (2)
    begin
      wr(8'h1c, 32'h1);
      wait_irq(20, c);
      check(32'(c < 20), 32'h1);
    end
    rdr(8'h10);
    check(rd, 32'h0);
    rdr(8'h0c);
    check(rd, 32'h0);
    rdr(8'h08);
    check(rd, 32'h1f40);
  endtask
  // Two-sample triggered run: shunt 4, bus 3 cycles
  task automatic t_single();
    wr(8'h14, 32'h800);
    wr(8'h00, 32'h20b);
    wr(8'h1c, 32'h1);
    wait_irq(30, c);
    check(32'(c), 32'ha);
    rdr(8'h04);
    check(rd, 32'h1f4);
    rdr(8'h10);
    check(rd, 32'h1f4);
    rdr(8'h0c);
    check(rd, 32'h1e7);
    repeat (30) @(posedge clk_sys);
    #1;
    check({31'h0, conv_shunt | conv_bus}, 32'h0);
    @(posedge clk_sys);
  endtask
  // Same mode rewritten re-runs; reads meanwhile see old set
  task automatic t_retrig();
    rdr(8'h18);
    check(rd & 32'h1, 32'h1);
    rdr(8'h18);
    check(rd & 32'h1, 32'h0);
    wr(8'h00, 32'h20b);
    #1;
    check({31'h0, conv_shunt}, 32'h1);
    @(posedge clk_sys);
    wr(8'h1c, 32'h1);
    rdr(8'h04);
    check(rd, 32'h1f4);
    rdr(8'h10);
    check(rd, 32'h1f4);
    rdr(8'h0c);
    check(rd, 32'h1e7);
    wait_irq(30, c);
    check(32'(c <= 3), 32'h1);
  endtask
  // Every mode code 1 to 6: only the enabled windows appear, none when off
  task automatic t_modes();
    logic s;
    logic b;
    for (int m = 1; m < 7; m++)
    begin
      wr(8'h00, 32'(m));
      s = 1'b0;
      b = 1'b0;
      repeat (20)
      begin
        #1;
        s |= conv_shunt;
        b |= conv_bus;
        @(posedge clk_sys);
      end
      check({30'h0, b, s}, 32'(m % 4));
    end
  endtask
  // Power-down, access while off, wake with recovery interrupt
  task automatic t_pd();
    wr(8'h20, 32'h2);
    wr(8'h1c, 32'h3);
    wr(8'h00, 32'h0);
    #1;
    check({31'h0, front_end_on}, 32'h0);
    @(posedge clk_sys);
    wr(8'h14, 32'h1234);
    rdr(8'h14);
    check(rd, 32'h1234);
    repeat (20) @(posedge clk_sys);
    #1;
    check({30'h0, front_end_on, irq}, 32'h0);
    @(posedge clk_sys);
    wr(8'h00, 32'h127);
    wait_irq(20, c);
    check(32'(c <= 3), 32'h1);
    wr(8'h1c, 32'h2);
    repeat (20) @(posedge clk_sys);
    #1;
    check({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    rdr(8'h1c);
    check(rd, 32'h1);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_zero_cal();
    t_single();
    t_retrig();
    t_modes();
    t_pd();
    finish_test();
  end
  // Whole run is a few hundred cycles; this cuts a hang
  initial
  begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule
